// ---- bench/pts_host_model.sv ----
// Host software side of the register port, reads only
module pts_host_model (
  input wire logic clk_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_hit_i,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
  end
  // One strobe cycle, then address inverted
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge clk_i);
    #1;
    reg_rd_o = 1'b1;
    reg_addr_o = a;
    @(posedge clk_i);
    #1;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
    h = reg_hit_i;
  endtask : read
  // Software acts only on defined toggle codes
  function automatic logic tog_defined(input logic [2:0] c);
    return c inside {3'b000, 3'b001, 3'b010, 3'b101, 3'b110, 3'b111};
  endfunction : tog_defined
endmodule : pts_host_model

// ---- bench/pts_status_regs_properties.sv ----
module pts_status_regs_properties
  import pts_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_hit_o,
  input wire logic tx_start_cmd_i,
  input wire logic tx_nack_i,
  input wire logic hard_reset_sent_i,
  input wire logic ack_sent_i,
  input wire logic hard_reset_rx_i,
  input wire logic pd_reset_i,
  input wire logic [3:0] power_enable_field_i,
  input wire logic [1:0] internal_power_request_i,
  input wire logic [3:0] effective_power_o,
  input wire logic toggle_enable_i,
  input wire logic settle_src_cc1_i,
  input wire logic settle_src_cc2_i,
  input wire logic settle_snk_cc1_i,
  input wire logic settle_snk_cc2_i,
  input wire logic settle_audio_i,
  input wire logic settled_source_line1_o,
  input wire logic vconn_overcurrent_i,
  input wire logic overtemp_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Read strobes
  logic rd_sr, rd_ts, rd_ev, rd_ack, any_settle;
  logic [3:0] ext;
  assign rd_sr = reg_rd_i && reg_addr_i == PTS_ADDR_FAIL_RST_STATUS;
  assign rd_ts = reg_rd_i && reg_addr_i == PTS_ADDR_TOGGLE_RX_STATUS;
  assign rd_ev = reg_rd_i && reg_addr_i == PTS_ADDR_PD_EVENT_FLAGS;
  assign rd_ack = reg_rd_i && reg_addr_i == PTS_ADDR_ACK_SENT_FLAGS;
  assign any_settle = settle_src_cc1_i | settle_src_cc2_i | settle_snk_cc1_i | settle_snk_cc2_i
    | settle_audio_i;
  assign ext = {internal_power_request_i, power_enable_field_i[1:0]};

  a_unmapped_read: assert property (
    reg_rd_i && reg_addr_i[7:2] != 6'h0F |=> !reg_hit_o && reg_rdata_o == 8'h00)
    else $error("Unmapped read hit");
  a_hard_rx_flag: assert property (
    hard_reset_rx_i ##1 !rd_ev [*2] ##1 rd_ev |=> reg_rdata_o[PTS_EV_HARD_RX_BIT])
    else $error("Hard rx flag lost");
  a_hard_sent_flag: assert property (
    hard_reset_sent_i ##1 !rd_ev [*2] ##1 rd_ev |=> reg_rdata_o[PTS_EV_HARD_SENT_BIT])
    else $error("Hard sent flag lost");
  a_fault_flag: assert property (
    (vconn_overcurrent_i || overtemp_i) ##1 !rd_ev [*2] ##1 rd_ev |=> reg_rdata_o[7])
    else $error("Fault flag lost");
  a_ack_read_clear: assert property (
    (rd_ack && !ack_sent_i) ##1 !(rd_ack || ack_sent_i) ##1 rd_ack |=> !reg_rdata_o[0])
    else $error("Ack flag not cleared");
  a_set_wins_clear: assert property (
    (rd_ack && ack_sent_i) ##1 !rd_ack ##1 rd_ack |=> reg_rdata_o[0])
    else $error("Event lost on read");
  a_status_hard_rx: assert property (
    hard_reset_rx_i ##1 !pd_reset_i ##1 rd_sr |=> reg_rdata_o[PTS_SR_HARD_RST_BIT])
    else $error("Hard rx status unset");
  a_fail_cmd_clear: assert property (
    !tx_nack_i [*2] ##1 (tx_start_cmd_i && !tx_nack_i) ##1 !tx_nack_i ##1 rd_sr
    |=> reg_rdata_o[5:4] == 2'b00)
    else $error("Failure status kept");
  a_power_max_rule: assert property (
    $past(rst_n_i) && $stable(internal_power_request_i)
    |-> effective_power_o == ((power_enable_field_i > ext) ? power_enable_field_i : ext))
    else $error("Power not the maximum");
  a_toggle_run_code: assert property (
    $rose(toggle_enable_i) && !any_settle ##1 rd_ts |=> reg_rdata_o[5:3] == PTS_TOG_RUNNING)
    else $error("Toggle not running");
  a_audio_source1: assert property (
    (rd_ts && !$rose(toggle_enable_i)) ##1 (reg_rdata_o[5:3] == PTS_TOG_AUDIO)
    |-> settled_source_line1_o)
    else $error("Audio not on source 1");
endmodule : pts_status_regs_properties

bind pts_status_regs pts_status_regs_properties u_props (.*);

// ---- bench/tb_pd_toggle_status_irq_regs.sv ----
module tb_pd_toggle_status_irq_regs
  import pts_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_rd_i, reg_hit_o, retransmit_req_o, soft_reset_req_o, hard_reset_req_o, h;
  logic settled_source_line1_o, event_pending_o, sf;
  logic [7:0] reg_addr_i, reg_rdata_o, d;
  logic [3:0] effective_power_o;
  logic hard_reset_rx_i, soft_reset_rx_i, hard_reset_sent_i, ack_sent_i, vconn_overcurrent_i;
  logic overtemp_i, tx_start_cmd_i, tx_nack_i, tx_ack_i, transmitter_on_cmd_i;
  logic send_hard_reset_cmd_i, pd_reset_i, rx_fifo_write_i, settle_src_cc1_i, settle_src_cc2_i;
  logic settle_snk_cc1_i, settle_snk_cc2_i, settle_audio_i;
  logic auto_retry_enable_i = 1'b1;
  logic auto_soft_reset_enable_i = 1'b0;
  logic auto_hard_reset_enable_i = 1'b0;
  logic toggle_enable_i = 1'b0;
  logic ack_sent_event_mask_i = 1'b0;
  logic [1:0] retry_count_i = 2'h0;
  logic [1:0] internal_power_request_i = 2'h0;
  logic [2:0] rx_sop_type_i = 3'h0;
  logic [3:0] power_enable_field_i = 4'h0;
  logic [7:0] pd_event_mask_i = 8'h00;
  logic [17:0] ev = '0;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_rt, n_sr, n_hr;
  localparam logic [17:0] EVT [6] = '{18'h1, 18'h2, 18'h4, 18'h10, 18'h20, 18'h8};
  localparam logic [7:0] EXP [6] = '{8'h01, 8'h02, 8'h08, 8'h80, 8'h80, 8'h01};
  localparam int CMD [3] = '{6, 9, 10};
  localparam int TBIT [5] = '{17, 13, 14, 15, 16};
  localparam logic [2:0] TCODE [5] = '{PTS_TOG_AUDIO, PTS_TOG_SRC_CC1, PTS_TOG_SRC_CC2,
    PTS_TOG_SNK_CC1, PTS_TOG_SNK_CC2};
  wire [7:0] pend = {7'h00, event_pending_o};
  // Pulse inputs share one vector
  assign {settle_audio_i, settle_snk_cc2_i, settle_snk_cc1_i, settle_src_cc2_i, settle_src_cc1_i,
    rx_fifo_write_i, pd_reset_i, send_hard_reset_cmd_i, transmitter_on_cmd_i, tx_ack_i, tx_nack_i,
    tx_start_cmd_i, overtemp_i, vconn_overcurrent_i, ack_sent_i, hard_reset_sent_i,
    soft_reset_rx_i, hard_reset_rx_i} = ev;

  always #5 clk_i = ~clk_i;
  pts_status_regs DUT (.*);
  pts_host_model host (.clk_i, .reg_rdata_i(reg_rdata_o), .reg_hit_i(reg_hit_o),
    .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i));
  // Tracker request pulses
  always @(posedge clk_i) begin
    n_rt += retransmit_req_o;
    n_sr += soft_reset_req_o;
    n_hr += hard_reset_req_o;
  end

  function automatic logic [3:0] pmax(input logic [3:0] f, input logic [1:0] r);
    return (f > {r, f[1:0]}) ? f : {r, f[1:0]};
  endfunction : pmax
  function automatic logic [7:0] sop_bits(input logic [2:0] t);
    return (t == PTS_SOP_PLAIN) ? 8'h01 : (t == PTS_SOP_PRIME_DBG) ? 8'h02 :
      (t == PTS_SOP_DPRIME_DBG) ? 8'h04 : 8'h00;
  endfunction : sop_bits
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic step;
    @(posedge clk_i);
    #1;
  endtask : step
  task automatic fire(input logic [17:0] m);
    step();
    ev = m;
    step();
    ev = '0;
  endtask : fire
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host.read(a, d, h);
    chk($sformatf("reg %h", a), exp, d);
  endtask : rdc
  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h6e74));
    repeat (8) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    // Reset values and one unmapped address
    for (int a = 8'h3C; a < 8'h41; a++) begin
      host.read(a[7:0], d, h);
      chk("reset value", 8'h00, d);
      chk("hit", {7'h00, a < 8'h40}, {7'h00, h});
    end
    // Directly driven flags
    foreach (EVT[i]) begin
      fire(EVT[i]);
      rdc(PTS_ADDR_PD_EVENT_FLAGS + 8'(i == 5), EXP[i]);
      rdc(PTS_ADDR_PD_EVENT_FLAGS + 8'(i == 5), 8'h00);
    end
    rdc(PTS_ADDR_FAIL_RST_STATUS, 8'h03);
    fire(18'h800);
    rdc(PTS_ADDR_FAIL_RST_STATUS, 8'h00);
    // Event in its clearing read cycle
    fork
      fire(18'h8);
      host.read(PTS_ADDR_ACK_SENT_FLAGS, d, h);
    join
    rdc(PTS_ADDR_ACK_SENT_FLAGS, 8'h01);
    // Retry counts and clearing commands
    for (int n = 0; n < 4; n++) begin
      sf = (n != 3);
      retry_count_i = n[1:0];
      auto_soft_reset_enable_i = sf;
      auto_hard_reset_enable_i = 1'($urandom_range(1));
      n_rt = 0;
      n_sr = 0;
      n_hr = 0;
      fire(18'h40);
      repeat (sf ? 2 * n + 2 : n + 1) fire(18'h80);
      repeat (2) step();
      rdc(PTS_ADDR_FAIL_RST_STATUS, {2'b00, sf, 1'b1, 4'h0});
      rdc(PTS_ADDR_PD_EVENT_FLAGS, {2'b00, sf, 1'b1, 4'h0});
      chk("retransmits", 8'(n * (sf + 1)), 8'(n_rt));
      chk("soft requests", {7'h00, sf}, 8'(n_sr));
      chk("hard requests", {7'h00, sf & auto_hard_reset_enable_i}, 8'(n_hr));
      fire(18'h1 << CMD[n % 3]);
      rdc(PTS_ADDR_FAIL_RST_STATUS, 8'h00);
    end
    fire(18'h40);
    fire(18'h100);
    rdc(PTS_ADDR_PD_EVENT_FLAGS, 8'h04);
    // Every ordered-set type
    for (int i = 0; i < 5; i++) begin
      rx_sop_type_i = 3'((i + 2) % 5);
      fire(18'h1000);
      rdc(PTS_ADDR_TOGGLE_RX_STATUS, sop_bits(rx_sop_type_i));
    end
    // Every settled toggle result
    foreach (TBIT[i]) begin
      toggle_enable_i = 1'b0;
      step();
      toggle_enable_i = 1'b1;
      rdc(PTS_ADDR_TOGGLE_RX_STATUS, 8'h00);
      fire(18'h1 << TBIT[i]);
      rdc(PTS_ADDR_TOGGLE_RX_STATUS, {2'b00, TCODE[i], 3'b000});
      chk("defined", 8'h01, {7'h00, host.tog_defined(d[5:3])});
      chk("source line1", {7'h00, TCODE[i] inside {PTS_TOG_SRC_CC1, PTS_TOG_AUDIO}},
        {7'h00, settled_source_line1_o});
      rdc(PTS_ADDR_PD_EVENT_FLAGS, 8'h40);
    end
    // Pending through the masks
    pd_event_mask_i = 8'hFF;
    ack_sent_event_mask_i = 1'b1;
    fire(18'h18);
    chk("pending", 8'h00, pend);
    ack_sent_event_mask_i = 1'b0;
    step();
    chk("pending", 8'h01, pend);
    ack_sent_event_mask_i = 1'b1;
    pd_event_mask_i = 8'($urandom) & 8'h7F;
    step();
    chk("pending", 8'h01, pend);
    rdc(PTS_ADDR_PD_EVENT_FLAGS, 8'h80);
    rdc(PTS_ADDR_ACK_SENT_FLAGS, 8'h01);
    chk("pending", 8'h00, pend);
    // Random power vectors
    repeat (20) begin
      power_enable_field_i = 4'($urandom_range(15));
      internal_power_request_i = 2'($urandom_range(3));
      repeat (2) step();
      chk("power", {4'h0, pmax(power_enable_field_i, internal_power_request_i)},
        {4'h0, effective_power_o});
      rdc(PTS_ADDR_FAIL_RST_STATUS, {4'h0, internal_power_request_i, 2'b00});
    end
    // Reset in mid-run with a flag pending
    fire(18'h10);
    rst_n_i = 1'b0;
    repeat (2) step();
    rst_n_i = 1'b1;
    rdc(PTS_ADDR_PD_EVENT_FLAGS, 8'h00);
    end_sim();
  end
endmodule : tb_pd_toggle_status_irq_regs

// ---- hw/pts_event_flags.sv ----
// Sticky read-to-clear flag group; a set in the clearing cycle survives
module pts_event_flags #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] set_i,
  input wire logic clr_i,
  output logic [W-1:0] flags_o
);

  // Set wins over clear so no event is lost at read time
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_o <= '0;
    end else begin
      flags_o <= (flags_o & ~{W{clr_i}}) | set_i;
    end
  end

endmodule : pts_event_flags

// ---- hw/pts_retry_tracker.sv ----
// Follows one packet through its retries and the optional soft reset
module pts_retry_tracker
  import pts_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tx_start_i,
  input wire logic tx_nack_i,
  input wire logic tx_ack_i,
  input wire logic auto_retry_enable_i,
  input wire logic [1:0] retry_count_i,
  input wire logic auto_soft_reset_enable_i,
  input wire logic auto_hard_reset_enable_i,
  output logic retransmit_req_o,
  output logic soft_reset_req_o,
  output logic hard_reset_req_o,
  pts_tx_if.tracker tx_ev
);

  typedef enum logic [1:0] {
    PTS_TRK_IDLE = 2'b00,
    PTS_TRK_PACKET = 2'b01,
    PTS_TRK_SOFT = 2'b10
  } pts_trk_e;

  pts_trk_e state;
  logic [1:0] fails;
  logic exhausted;

  // Without auto retry the first missing acknowledge ends the attempt
  assign exhausted = !auto_retry_enable_i || (fails == retry_count_i);

  // Sequence state and failure count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= PTS_TRK_IDLE;
      fails <= 2'h0;
    end else if (tx_start_i) begin
      state <= PTS_TRK_PACKET;
      fails <= 2'h0;
    end else begin
      unique case (state)
        PTS_TRK_IDLE: begin
          fails <= 2'h0;
        end
        PTS_TRK_PACKET: begin
          if (tx_ack_i) begin
            state <= PTS_TRK_IDLE;
          end else if (tx_nack_i && exhausted) begin
            fails <= 2'h0;
            state <= auto_soft_reset_enable_i ? PTS_TRK_SOFT : PTS_TRK_IDLE;
          end else if (tx_nack_i) begin
            fails <= fails + 2'h1;
          end
        end
        PTS_TRK_SOFT: begin
          if (tx_ack_i || (tx_nack_i && exhausted)) begin
            state <= PTS_TRK_IDLE;
          end else if (tx_nack_i) begin
            fails <= fails + 2'h1;
          end
        end
      endcase
    end
  end

  // One-cycle outcome pulses, registered
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      retransmit_req_o <= 1'b0;
      soft_reset_req_o <= 1'b0;
      hard_reset_req_o <= 1'b0;
      tx_ev.retry_fail <= 1'b0;
      tx_ev.soft_fail <= 1'b0;
      tx_ev.tx_acked <= 1'b0;
    end else begin
      retransmit_req_o <= !tx_start_i && tx_nack_i && !exhausted && (state != PTS_TRK_IDLE);
      tx_ev.retry_fail <= !tx_start_i && tx_nack_i && exhausted
                          && (state == PTS_TRK_PACKET);
      soft_reset_req_o <= !tx_start_i && tx_nack_i && exhausted
                          && (state == PTS_TRK_PACKET) && auto_soft_reset_enable_i;
      tx_ev.soft_fail <= !tx_start_i && tx_nack_i && exhausted
                         && (state == PTS_TRK_SOFT);
      hard_reset_req_o <= !tx_start_i && tx_nack_i && exhausted
                          && (state == PTS_TRK_SOFT) && auto_hard_reset_enable_i;
      tx_ev.tx_acked <= !tx_start_i && tx_ack_i && (state != PTS_TRK_IDLE);
    end
  end

endmodule : pts_retry_tracker

// ---- hw/pts_status_regs.sv ----
// Behaviour
// - Soft-fail status sets when the soft reset and all its retries go unacknowledged.
// - Transmit start, transmitter-on or send-hard-reset command clears both failure bits.
// - Retry-fail status sets when every retransmission of a packet went unacknowledged.
// - Report internal power request; effective power is higher of both vectors.
// - Soft-reset-received status sets when a received packet is a soft reset.
// - Hard-reset-received status sets when a hard reset ordered set arrives.
// - Toggle code 000 while running, 001/010 when settled source on CC1/CC2.
// - Toggle code 101/110 when settled sink on CC1/CC2.
// - Audio accessory reads 111 and settles in the source-on-CC1 stop state.
// - Bit 2 flags last packet SOP double-prime debug, bit 1 SOP prime debug.
// - Bit 0 flags last receive FIFO packet carried a plain SOP.
// - Bit 7 event latches on VCONN over-current or over-temperature; read clears.
// - Bit 6 event latches when toggling ends on a detected attach.
// - Bit 5 event latches when the automatic soft reset sequence fails.
// - Bit 4 event latches when all automatic retransmissions fail.
// - Bit 3 event latches after a hard reset ordered set is sent.
// - Bit 2 event latches when a sent packet is acknowledged by GoodCRC.
// - Bit 1 event latches on receipt of a soft reset packet.
// - Bit 0 of first event register latches on received hard reset.
// - Bit 0 of second event register latches after a GoodCRC is sent.
// - Each event flag has a mask bit that keeps it from interrupting.
// - Auto soft reset and auto hard reset each need their own enable.
module pts_status_regs
  import pts_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register read port of the serial management front end
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,
  // Transmit commands and outcomes
  input wire logic tx_start_cmd_i,
  input wire logic transmitter_on_cmd_i,
  input wire logic send_hard_reset_cmd_i,
  input wire logic tx_nack_i,
  input wire logic tx_ack_i,
  input wire logic hard_reset_sent_i,
  input wire logic ack_sent_i,
  // Retry configuration
  input wire logic auto_retry_enable_i,
  input wire logic [1:0] retry_count_i,
  input wire logic auto_soft_reset_enable_i,
  input wire logic auto_hard_reset_enable_i,
  output logic retransmit_req_o,
  output logic soft_reset_req_o,
  output logic hard_reset_req_o,
  // Receive path
  input wire logic soft_reset_rx_i,
  input wire logic hard_reset_rx_i,
  input wire logic rx_fifo_write_i,
  input wire logic [2:0] rx_sop_type_i,
  input wire logic pd_reset_i,
  // Power
  input wire logic [3:0] power_enable_field_i,
  input wire logic [1:0] internal_power_request_i,
  output logic [3:0] effective_power_o,
  // Toggle
  input wire logic toggle_enable_i,
  input wire logic settle_src_cc1_i,
  input wire logic settle_src_cc2_i,
  input wire logic settle_snk_cc1_i,
  input wire logic settle_snk_cc2_i,
  input wire logic settle_audio_i,
  output logic settled_source_line1_o,
  // Fault events
  input wire logic vconn_overcurrent_i,
  input wire logic overtemp_i,
  // Masks
  input wire logic [7:0] pd_event_mask_i,
  input wire logic ack_sent_event_mask_i,
  output logic event_pending_o
);

  pts_tx_if tx_ev ();

  logic soft_reset_seq_failed;
  logic retransmit_exhausted;
  logic soft_reset_received;
  logic hard_reset_received;
  logic [1:0] pwr_req;
  logic [3:0] internal_vector;
  pts_toggle_e toggle_state_code;
  logic toggle_en_d;
  logic toggle_done;
  logic last_rx_dprime_debug;
  logic last_rx_prime_debug;
  logic last_rx_plain_start;
  logic fail_clear;
  logic rd_pd_events;
  logic rd_ack_events;
  logic [7:0] pd_event_set;
  logic [7:0] pd_event_flags;
  logic [0:0] ack_sent_event_flags;
  logic [7:0] fail_rst_status;
  logic [7:0] toggle_rx_status;
  logic [7:0] next_rdata;

  // Retry and soft reset sequencing
  pts_retry_tracker u_tracker (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tx_start_i(tx_start_cmd_i),
    .tx_nack_i(tx_nack_i),
    .tx_ack_i(tx_ack_i),
    .auto_retry_enable_i(auto_retry_enable_i),
    .retry_count_i(retry_count_i),
    .auto_soft_reset_enable_i(auto_soft_reset_enable_i),
    .auto_hard_reset_enable_i(auto_hard_reset_enable_i),
    .retransmit_req_o(retransmit_req_o),
    .soft_reset_req_o(soft_reset_req_o),
    .hard_reset_req_o(hard_reset_req_o),
    .tx_ev(tx_ev.tracker)
  );

  // Any of the three commands starts a fresh transmit history
  assign fail_clear = tx_start_cmd_i || transmitter_on_cmd_i || send_hard_reset_cmd_i;

  // Failure status; a failure in the clearing cycle still shows
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_reset_seq_failed <= 1'b0;
      retransmit_exhausted <= 1'b0;
    end else begin
      soft_reset_seq_failed <= (soft_reset_seq_failed && !fail_clear)
                               || tx_ev.soft_fail;
      retransmit_exhausted <= (retransmit_exhausted && !fail_clear)
                              || tx_ev.retry_fail;
    end
  end

  // Received reset status, held until the PD logic is reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_reset_received <= 1'b0;
      hard_reset_received <= 1'b0;
    end else begin
      soft_reset_received <= (soft_reset_received && !pd_reset_i) || soft_reset_rx_i;
      hard_reset_received <= (hard_reset_received && !pd_reset_i) || hard_reset_rx_i;
    end
  end

  // Internal power request captured so the status read is stable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_req <= 2'h0;
    end else begin
      pwr_req <= internal_power_request_i;
    end
  end

  // Effective power is the numerically higher vector
  assign internal_vector = {pwr_req, power_enable_field_i[1:0]};
  assign effective_power_o = (internal_vector > power_enable_field_i)
                             ? internal_vector : power_enable_field_i;

  // Toggle result; enabling the toggle restarts it from running
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      toggle_en_d <= 1'b0;
      toggle_state_code <= PTS_TOG_RUNNING;
      toggle_done <= 1'b0;
    end else begin
      toggle_en_d <= toggle_enable_i;
      toggle_done <= 1'b0;
      if (toggle_enable_i && !toggle_en_d) begin
        toggle_state_code <= PTS_TOG_RUNNING;
      end else if (toggle_enable_i && toggle_state_code == PTS_TOG_RUNNING) begin
        // Audio wins: both lines carry Ra, so it outranks a CC1 source match
        if (settle_audio_i) begin
          toggle_state_code <= PTS_TOG_AUDIO;
          toggle_done <= 1'b1;
        end else if (settle_src_cc1_i) begin
          toggle_state_code <= PTS_TOG_SRC_CC1;
          toggle_done <= 1'b1;
        end else if (settle_src_cc2_i) begin
          toggle_state_code <= PTS_TOG_SRC_CC2;
          toggle_done <= 1'b1;
        end else if (settle_snk_cc1_i) begin
          toggle_state_code <= PTS_TOG_SNK_CC1;
          toggle_done <= 1'b1;
        end else if (settle_snk_cc2_i) begin
          toggle_state_code <= PTS_TOG_SNK_CC2;
          toggle_done <= 1'b1;
        end
      end
    end
  end

  // Audio accessory parks in the same stop state as source on CC1
  assign settled_source_line1_o = (toggle_state_code == PTS_TOG_SRC_CC1)
                                  || (toggle_state_code == PTS_TOG_AUDIO);

  // Ordered-set type of the last packet placed in the receive FIFO
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_rx_dprime_debug <= 1'b0;
      last_rx_prime_debug <= 1'b0;
      last_rx_plain_start <= 1'b0;
    end else if (rx_fifo_write_i) begin
      last_rx_dprime_debug <= (rx_sop_type_i == PTS_SOP_DPRIME_DBG);
      last_rx_prime_debug <= (rx_sop_type_i == PTS_SOP_PRIME_DBG);
      last_rx_plain_start <= (rx_sop_type_i == PTS_SOP_PLAIN);
    end
  end

  // Read strobes that clear the event registers
  assign rd_pd_events = reg_rd_i && (reg_addr_i == PTS_ADDR_PD_EVENT_FLAGS);
  assign rd_ack_events = reg_rd_i && (reg_addr_i == PTS_ADDR_ACK_SENT_FLAGS);

  // Event sources of the first event register
  always_comb begin
    pd_event_set = 8'h00;
    pd_event_set[PTS_EV_OCP_TEMP_BIT] = vconn_overcurrent_i || overtemp_i;
    pd_event_set[PTS_EV_TOG_DONE_BIT] = toggle_done;
    pd_event_set[PTS_EV_SOFT_FAIL_BIT] = tx_ev.soft_fail;
    pd_event_set[PTS_EV_RETRY_FAIL_BIT] = tx_ev.retry_fail;
    pd_event_set[PTS_EV_HARD_SENT_BIT] = hard_reset_sent_i;
    pd_event_set[PTS_EV_TX_ACKED_BIT] = tx_ev.tx_acked;
    pd_event_set[PTS_EV_SOFT_RX_BIT] = soft_reset_rx_i;
    pd_event_set[PTS_EV_HARD_RX_BIT] = hard_reset_rx_i;
  end

  pts_event_flags #(
    .W(8)
  ) u_pd_events (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .set_i(pd_event_set),
    .clr_i(rd_pd_events),
    .flags_o(pd_event_flags)
  );

  pts_event_flags #(
    .W(1)
  ) u_ack_events (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .set_i(ack_sent_i),
    .clr_i(rd_ack_events),
    .flags_o(ack_sent_event_flags)
  );

  // Unmasked flags summarised for the device interrupt logic
  assign event_pending_o = |(pd_event_flags & ~pd_event_mask_i)
                           || (ack_sent_event_flags[0] && !ack_sent_event_mask_i);

  // Status register images; reserved bits read as zero
  always_comb begin
    fail_rst_status = PTS_RST_FAIL_RST_STATUS;
    fail_rst_status[PTS_SR_SOFT_FAIL_BIT] = soft_reset_seq_failed;
    fail_rst_status[PTS_SR_RETRY_FAIL_BIT] = retransmit_exhausted;
    fail_rst_status[PTS_SR_PWR_REQ_LSB +: 2] = pwr_req;
    fail_rst_status[PTS_SR_SOFT_RST_BIT] = soft_reset_received;
    fail_rst_status[PTS_SR_HARD_RST_BIT] = hard_reset_received;
    toggle_rx_status = PTS_RST_TOGGLE_RX_STATUS;
    toggle_rx_status[PTS_TS_TOGGLE_LSB +: 3] = toggle_state_code;
    toggle_rx_status[PTS_TS_DPRIME_DBG_BIT] = last_rx_dprime_debug;
    toggle_rx_status[PTS_TS_PRIME_DBG_BIT] = last_rx_prime_debug;
    toggle_rx_status[PTS_TS_PLAIN_SOP_BIT] = last_rx_plain_start;
  end

  // Read multiplexer; unmapped addresses return zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr_i)
      PTS_ADDR_FAIL_RST_STATUS: next_rdata = fail_rst_status;
      PTS_ADDR_TOGGLE_RX_STATUS: next_rdata = toggle_rx_status;
      PTS_ADDR_PD_EVENT_FLAGS: next_rdata = pd_event_flags;
      PTS_ADDR_ACK_SENT_FLAGS: next_rdata = {7'h00, ack_sent_event_flags};
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data captured with the pre-clear flag values
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
      reg_hit_o <= 1'b0;
    end else begin
      reg_hit_o <= 1'b0;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
        reg_hit_o <= (reg_addr_i >= PTS_ADDR_FAIL_RST_STATUS)
                     && (reg_addr_i <= PTS_ADDR_ACK_SENT_FLAGS);
      end
    end
  end

endmodule : pts_status_regs

// ---- pkg/pts_pkg.sv ----
package pts_pkg;

  // Register addresses on the serial management port
  localparam logic [7:0] PTS_ADDR_FAIL_RST_STATUS = 8'h3C;
  localparam logic [7:0] PTS_ADDR_TOGGLE_RX_STATUS = 8'h3D;
  localparam logic [7:0] PTS_ADDR_PD_EVENT_FLAGS = 8'h3E;
  localparam logic [7:0] PTS_ADDR_ACK_SENT_FLAGS = 8'h3F;

  // Reset values
  localparam logic [7:0] PTS_RST_FAIL_RST_STATUS = 8'h00;
  localparam logic [7:0] PTS_RST_TOGGLE_RX_STATUS = 8'h00;
  localparam logic [7:0] PTS_RST_PD_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] PTS_RST_ACK_SENT_FLAGS = 8'h00;

  // Failure/reset status field positions
  localparam int PTS_SR_SOFT_FAIL_BIT = 5;
  localparam int PTS_SR_RETRY_FAIL_BIT = 4;
  localparam int PTS_SR_PWR_REQ_LSB = 2;
  localparam int PTS_SR_SOFT_RST_BIT = 1;
  localparam int PTS_SR_HARD_RST_BIT = 0;

  // Toggle / receive type status field positions
  localparam int PTS_TS_TOGGLE_LSB = 3;
  localparam int PTS_TS_DPRIME_DBG_BIT = 2;
  localparam int PTS_TS_PRIME_DBG_BIT = 1;
  localparam int PTS_TS_PLAIN_SOP_BIT = 0;

  // Event flag bit positions, first event register
  localparam int PTS_EV_OCP_TEMP_BIT = 7;
  localparam int PTS_EV_TOG_DONE_BIT = 6;
  localparam int PTS_EV_SOFT_FAIL_BIT = 5;
  localparam int PTS_EV_RETRY_FAIL_BIT = 4;
  localparam int PTS_EV_HARD_SENT_BIT = 3;
  localparam int PTS_EV_TX_ACKED_BIT = 2;
  localparam int PTS_EV_SOFT_RX_BIT = 1;
  localparam int PTS_EV_HARD_RX_BIT = 0;
  // Second event register
  localparam int PTS_EV_ACK_SENT_BIT = 0;

  // Settled toggle result, encoded as reported in the toggle field
  typedef enum logic [2:0] {
    PTS_TOG_RUNNING = 3'b000,
    PTS_TOG_SRC_CC1 = 3'b001,
    PTS_TOG_SRC_CC2 = 3'b010,
    PTS_TOG_SNK_CC1 = 3'b101,
    PTS_TOG_SNK_CC2 = 3'b110,
    PTS_TOG_AUDIO = 3'b111
  } pts_toggle_e;

  // Ordered-set type of a packet written to the receive FIFO
  typedef enum logic [2:0] {
    PTS_SOP_PLAIN = 3'b000,
    PTS_SOP_PRIME = 3'b001,
    PTS_SOP_DPRIME = 3'b010,
    PTS_SOP_PRIME_DBG = 3'b011,
    PTS_SOP_DPRIME_DBG = 3'b100
  } pts_sop_e;

endpackage : pts_pkg

// ---- pkg/pts_tx_if.sv ----
// Transmit outcome events from the retry tracker to the register bank
interface pts_tx_if;
  logic retry_fail;
  logic soft_fail;
  logic tx_acked;

  modport tracker (
    output retry_fail,
    output soft_fail,
    output tx_acked
  );

  modport bank (
    input retry_fail,
    input soft_fail,
    input tx_acked
  );
endinterface : pts_tx_if
